/* verilog/nas_status_word.sv */
// Status word, flag update and write-back control of the nibble ALU
`timescale 1ns/1ps
`default_nettype none
module nas_status_word (
   input  wire logic               clock,
   input  wire logic               reset_n,
   input  wire logic               op_valid,
   input  wire nas_pkg::nas_req_t  op_req,
   input  wire logic               sys_wr_en,
   input  wire logic [6:0]         sys_wr_addr,
   input  wire logic [3:0]         sys_wr_data,
   input  wire logic               sys_rd_en,
   input  wire logic [6:0]         sys_rd_addr,
   output logic [3:0]              sys_rd_data_q,
   output logic                    sys_rd_hit_q,
   output nas_pkg::nas_wb_t        wb_q,
   output logic                    skip_q,
   output nas_pkg::nas_flags_t     flags_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Datapath

   logic [3:0] alu_res;
   logic       alu_carry;
   logic       alu_is_arith;
   logic       alu_is_bit;
   logic       alu_is_cmp;
   logic       alu_stores;
   logic       alu_skip;

   nas_alu_core u_alu (
      .op       (op_req.op),
      .a        (op_req.a),
      .b        (op_req.b),
      .cy_in    (flags_q.cy),
      .bcd      (flags_q.bcd),
      .res      (alu_res),
      .carry    (alu_carry),
      .is_arith (alu_is_arith),
      .is_bit   (alu_is_bit),
      .is_cmp   (alu_is_cmp),
      .stores   (alu_stores),
      .skip     (alu_skip)
   );

   logic       do_arith;
   logic       do_rotate;
   logic       do_bit;
   logic       res_zero;
   logic       flags_wr;
   logic       mode_wr;
   logic [6:0] gen_addr;

   assign do_arith  = op_valid && alu_is_arith;
   assign do_rotate = op_valid && (op_req.op == nas_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY);
   assign do_bit    = op_valid && alu_is_bit;
   assign res_zero  = (alu_res == nas_pkg::NIB_ZERO);
   assign flags_wr  = sys_wr_en && (sys_wr_addr == nas_pkg::ADDR_FLAGS);
   assign mode_wr   = sys_wr_en && (sys_wr_addr == nas_pkg::ADDR_MODE);
   // Row pointer is fixed, so the general register is a row-0 column
   assign gen_addr  = {nas_pkg::ROW_POINTER, op_req.col};

   ////////////////////////////////////////////////////////////////////////////
   // Flag flip-flops, shared with the status word addresses

   // A software write to a status address wins over a same-cycle operation
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         flags_q <= nas_pkg::nas_flags_t'(nas_pkg::PSW_RESET);
      end else if (flags_wr) begin
         flags_q.cmp <= sys_wr_data[nas_pkg::FLAGS_CMP_BIT];
         flags_q.cy  <= sys_wr_data[nas_pkg::FLAGS_CY_BIT];
         flags_q.z   <= sys_wr_data[nas_pkg::FLAGS_Z_BIT];
      end else if (mode_wr) begin
         flags_q.bcd <= sys_wr_data[nas_pkg::MODE_BCD_BIT];
      end else begin
         if (do_arith) begin
            flags_q.cy <= alu_carry;
            if (!res_zero) begin
               flags_q.z <= 1'b0;
            end else if (!flags_q.cmp) begin
               flags_q.z <= 1'b1;
            end
         end
         if (do_rotate) begin
            flags_q.cy <= alu_carry;
         end
         if (do_bit) begin
            flags_q.cmp <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write-back and skip, one instruction per cycle

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wb_q.en <= 1'b0;
      end else begin
         // Arithmetic under compare hold computes but stores nothing
         wb_q.en <= op_valid && alu_stores && !(alu_is_arith && flags_q.cmp);
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wb_q.addr <= 7'h00;
         wb_q.data <= nas_pkg::NIB_ZERO;
      end else if (op_valid) begin
         wb_q.addr <= op_req.dest_gen ? gen_addr : op_req.m_addr;
         wb_q.data <= alu_res;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         skip_q <= 1'b0;
      end else begin
         skip_q <= op_valid && alu_skip;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System register read-back

   logic       rd_in_zero;
   logic [3:0] rd_value;

   assign rd_in_zero = (sys_rd_addr >= nas_pkg::SYS_ZERO_LO) &&
                       (sys_rd_addr <= nas_pkg::SYS_ZERO_HI);

   always_comb begin
      rd_value = nas_pkg::NIB_ZERO;
      if (sys_rd_addr == nas_pkg::ADDR_FLAGS) begin
         rd_value[nas_pkg::FLAGS_CMP_BIT] = flags_q.cmp;
         rd_value[nas_pkg::FLAGS_CY_BIT]  = flags_q.cy;
         rd_value[nas_pkg::FLAGS_Z_BIT]   = flags_q.z;
      end else if (sys_rd_addr == nas_pkg::ADDR_MODE) begin
         rd_value[nas_pkg::MODE_BCD_BIT] = flags_q.bcd;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sys_rd_data_q <= nas_pkg::NIB_ZERO;
         sys_rd_hit_q  <= 1'b0;
      end else if (sys_rd_en) begin
         sys_rd_data_q <= rd_value;
         sys_rd_hit_q  <= rd_in_zero || (sys_rd_addr == nas_pkg::ADDR_FLAGS) ||
                          (sys_rd_addr == nas_pkg::ADDR_MODE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock);
   endclocking

   default disable iff (!reset_n);

   logic       plain_op;
   logic [4:0] bin_sum;
   logic [4:0] bin_sum_c;

   assign plain_op  = op_valid && !sys_wr_en;
   assign bin_sum   = {1'b0, op_req.a} + {1'b0, op_req.b};
   assign bin_sum_c = bin_sum + {4'h0, flags_q.cy};

   property p_reset_clear;
      $rose(reset_n) |-> (flags_q == nas_pkg::nas_flags_t'(nas_pkg::PSW_RESET));
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("Status word not cleared by reset");

   property p_z_set;
      (plain_op && alu_is_arith && res_zero && !flags_q.cmp) |=> flags_q.z;
   endproperty
   a_z_set: assert property (p_z_set)
      else $error("Zero result did not set zero flag");

   property p_z_hold;
      (plain_op && alu_is_arith && res_zero && flags_q.cmp) |=> (flags_q.z == $past(flags_q.z));
   endproperty
   a_z_hold: assert property (p_z_hold)
      else $error("Zero flag changed under compare hold");

   property p_z_clear;
      (plain_op && alu_is_arith && !res_zero) |=> !flags_q.z;
   endproperty
   a_z_clear: assert property (p_z_clear)
      else $error("Non-zero result did not clear zero flag");

   property p_add_carry;
      (plain_op && (op_req.op == nas_pkg::OP_ADD) && !flags_q.bcd)
         |=> (flags_q.cy == $past(bin_sum[4]));
   endproperty
   a_add_carry: assert property (p_add_carry)
      else $error("Binary add carry wrong");

   property p_rotate_right_through_carry;
      (plain_op && (op_req.op == nas_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY)) |=> (flags_q.cy == $past(op_req.a[0]));
   endproperty
   a_rotate_right_through_carry: assert property (p_rotate_right_through_carry)
      else $error("Rotate did not load carry from bit 0");

   property p_no_store;
      (op_valid && alu_is_arith && flags_q.cmp) |=> !wb_q.en;
   endproperty
   a_no_store: assert property (p_no_store)
      else $error("Arithmetic stored under compare hold");

   property p_bit_clr;
      (plain_op && alu_is_bit) |=> !flags_q.cmp;
   endproperty
   a_bit_clr: assert property (p_bit_clr)
      else $error("Bit test did not clear compare flag");

   property p_cmp_cy;
      (plain_op && alu_is_cmp) |=> $stable(flags_q.cy);
   endproperty
   a_cmp_cy: assert property (p_cmp_cy)
      else $error("Comparison changed carry");

   property p_zero_window;
      (sys_rd_en && rd_in_zero) |=> (sys_rd_data_q == nas_pkg::NIB_ZERO) && sys_rd_hit_q;
   endproperty
   a_zero_window: assert property (p_zero_window)
      else $error("Unused system address read non-zero");

   property p_flags_read;
      (sys_rd_en && (sys_rd_addr == nas_pkg::ADDR_FLAGS))
         |=> (sys_rd_data_q == {$past(flags_q.cmp), $past(flags_q.cy), $past(flags_q.z), 1'b0});
   endproperty
   a_flags_read: assert property (p_flags_read)
      else $error("Flag nibble read-back wrong");

   property p_gen_row;
      (op_valid && op_req.dest_gen) |=> (wb_q.addr[6:4] == nas_pkg::ROW_POINTER);
   endproperty
   a_gen_row: assert property (p_gen_row)
      else $error("General register left row zero");

   property p_ske;
      (op_valid && (op_req.op == nas_pkg::OP_SKE) && (op_req.a == op_req.b))
         |=> skip_q && !wb_q.en;
   endproperty
   a_ske: assert property (p_ske)
      else $error("Equal compare did not skip");

   property p_mode_read;
      (sys_rd_en && (sys_rd_addr == nas_pkg::ADDR_MODE))
         |=> (sys_rd_data_q == {3'h0, $past(flags_q.bcd)}) && sys_rd_hit_q;
   endproperty
   a_mode_read: assert property (p_mode_read)
      else $error("Mode nibble read-back wrong");

   property p_miss_read;
      (sys_rd_en && (sys_rd_addr < nas_pkg::SYS_ZERO_LO))
         |=> (sys_rd_data_q == nas_pkg::NIB_ZERO) && !sys_rd_hit_q;
   endproperty
   a_miss_read: assert property (p_miss_read)
      else $error("Address below system window reported a hit");

   property p_flags_write;
      flags_wr |=> ({flags_q.cmp, flags_q.cy, flags_q.z} ==
                    $past(sys_wr_data[nas_pkg::FLAGS_CMP_BIT:nas_pkg::FLAGS_Z_BIT]));
   endproperty
   a_flags_write: assert property (p_flags_write)
      else $error("Flag nibble write did not reach the flag flip-flops");

   property p_mode_write;
      mode_wr |=> (flags_q.bcd == $past(sys_wr_data[nas_pkg::MODE_BCD_BIT]));
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("Mode nibble write did not reach the decimal flag");

   property p_bcd_add;
      (plain_op && (op_req.op == nas_pkg::OP_ADD) && flags_q.bcd)
         |=> (flags_q.cy == $past(bin_sum > nas_pkg::DEC_MAX));
   endproperty
   a_bcd_add: assert property (p_bcd_add)
      else $error("Decimal add carry wrong");

   property p_sub_borrow;
      (plain_op && (op_req.op == nas_pkg::OP_SUB) && !flags_q.bcd)
         |=> (flags_q.cy == $past(op_req.a < op_req.b));
   endproperty
   a_sub_borrow: assert property (p_sub_borrow)
      else $error("Binary subtract borrow wrong");

   property p_add_with_carry;
      (plain_op && (op_req.op == nas_pkg::OP_ADD_WITH_CARRY) && !flags_q.bcd)
         |=> (flags_q.cy == $past(bin_sum_c[4]));
   endproperty
   a_add_with_carry: assert property (p_add_with_carry)
      else $error("Add with carry ignored the carry flag");

   property p_logic_keep;
      (plain_op && (op_req.op inside {nas_pkg::OP_OR, nas_pkg::OP_AND, nas_pkg::OP_XOR}))
         |=> $stable(flags_q);
   endproperty
   a_logic_keep: assert property (p_logic_keep)
      else $error("Logical operation changed a flag");

   property p_rotate_right_through_carry_store;
      (op_valid && (op_req.op == nas_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY))
         |=> wb_q.en && (wb_q.data[2:0] == $past(op_req.a[3:1]));
   endproperty
   a_rotate_right_through_carry_store: assert property (p_rotate_right_through_carry_store)
      else $error("Rotate result not stored");

   property p_idle_quiet;
      !op_valid |=> !skip_q && !wb_q.en;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("Strobe raised without an instruction");

   property p_cmp_flags;
      (plain_op && alu_is_cmp) |=> $stable(flags_q.z) && $stable(flags_q.cmp);
   endproperty
   a_cmp_flags: assert property (p_cmp_flags)
      else $error("Comparison changed zero or compare flag");

   c_multi_compare: cover property (
      (plain_op && alu_is_arith && flags_q.cmp) ##1 (plain_op && alu_is_arith && flags_q.cmp)
         ##1 (plain_op && alu_is_bit));
   c_decimal_carry: cover property (plain_op && alu_is_arith && flags_q.bcd && alu_carry);
   c_rotate_one: cover property (plain_op && (op_req.op == nas_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY) && op_req.a[0]);
   c_flags_write: cover property (flags_wr ##1 (sys_rd_en && (sys_rd_addr == nas_pkg::ADDR_FLAGS)));

endmodule : nas_status_word
`default_nettype wire

/* verilog/nas_pkg.sv */
// Shared constants and types for the nibble ALU status word
package nas_pkg;

   localparam int ADDR_W = 7;
   localparam int NIB_W  = 4;
   localparam int ROW_W  = 3;
   localparam int COL_W  = 4;

   // System register map
   localparam logic [6:0] SYS_ZERO_LO = 7'h74;
   localparam logic [6:0] SYS_ZERO_HI = 7'h7D;
   localparam logic [6:0] ADDR_MODE   = 7'h7E;
   localparam logic [6:0] ADDR_FLAGS  = 7'h7F;

   // Bit positions inside the two status nibbles
   localparam int FLAGS_CMP_BIT = 3;
   localparam int FLAGS_CY_BIT  = 2;
   localparam int FLAGS_Z_BIT   = 1;
   localparam int MODE_BCD_BIT  = 0;

   localparam logic [2:0] ROW_POINTER = 3'h0;
   localparam logic [3:0] NIB_ZERO    = 4'h0;
   localparam logic [3:0] PSW_RESET   = 4'h0;

   // Decimal digit adjust
   localparam logic [4:0] DEC_MAX = 5'h09;
   localparam logic [4:0] DEC_ADJ = 5'h06;

   typedef enum logic [3:0] {
      OP_NOP   = 4'h0,
      OP_ADD   = 4'h1,
      OP_ADD_WITH_CARRY  = 4'h2,
      OP_SUB   = 4'h3,
      OP_SUBTRACT_WITH_BORROW  = 4'h4,
      OP_OR    = 4'h5,
      OP_AND   = 4'h6,
      OP_XOR   = 4'h7,
      OP_SKT   = 4'h8,
      OP_SKF   = 4'h9,
      OP_SKE   = 4'hA,
      OP_SKIP_IF_NOT_EQUAL  = 4'hB,
      OP_SKIP_IF_GREATER_EQUAL  = 4'hC,
      OP_SKIP_IF_LESS  = 4'hD,
      OP_ROTATE_RIGHT_THROUGH_CARRY  = 4'hE
   } nas_op_t;

   typedef struct packed {
      nas_op_t    op;
      logic [3:0] a;
      logic [3:0] b;
      logic       dest_gen;
      logic [3:0] col;
      logic [6:0] m_addr;
   } nas_req_t;

   typedef struct packed {
      logic cmp;
      logic cy;
      logic z;
      logic bcd;
   } nas_flags_t;

   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [3:0] data;
   } nas_wb_t;

endpackage : nas_pkg

/* verilog/nas_alu_core.sv */
// Combinational 4-bit datapath of the nibble ALU
`timescale 1ns/1ps
`default_nettype none
module nas_alu_core (
   input  wire nas_pkg::nas_op_t op,
   input  wire logic [3:0]       a,
   input  wire logic [3:0]       b,
   input  wire logic             cy_in,
   input  wire logic             bcd,
   output logic [3:0]            res,
   output logic                  carry,
   output logic                  is_arith,
   output logic                  is_bit,
   output logic                  is_cmp,
   output logic                  stores,
   output logic                  skip
);

   // Add one digit, binary or decimal; returns {carry, sum}
   function automatic logic [4:0] add_digit(input logic [3:0] x, input logic [3:0] y,
                                           input logic c, input logic dec);
      logic [4:0] s;
      s = {1'b0, x} + {1'b0, y} + {4'h0, c};
      if (dec && (s > nas_pkg::DEC_MAX)) begin
         s = {1'b1, 4'(s[3:0] + nas_pkg::DEC_ADJ[3:0])};
      end
      return s;
   endfunction : add_digit

   // Subtract one digit, binary or decimal; returns {borrow, diff}
   function automatic logic [4:0] sub_digit(input logic [3:0] x, input logic [3:0] y,
                                           input logic c, input logic dec);
      logic [4:0] s;
      s = {1'b0, x} - {1'b0, y} - {4'h0, c};
      if (dec && s[4]) begin
         s = {1'b1, 4'(s[3:0] - nas_pkg::DEC_ADJ[3:0])};
      end
      return s;
   endfunction : sub_digit

   logic [4:0] cmp_diff;

   always_comb begin
      res      = nas_pkg::NIB_ZERO;
      carry    = 1'b0;
      is_arith = 1'b0;
      is_bit   = 1'b0;
      is_cmp   = 1'b0;
      stores   = 1'b0;
      skip     = 1'b0;
      cmp_diff = sub_digit(a, b, 1'b0, 1'b0);
      unique case (op)
         nas_pkg::OP_ADD, nas_pkg::OP_ADD_WITH_CARRY: begin
            // Carry in only for the with-carry form
            {carry, res} = add_digit(a, b, (op == nas_pkg::OP_ADD_WITH_CARRY) & cy_in, bcd);
            is_arith     = 1'b1;
            stores       = 1'b1;
         end
         nas_pkg::OP_SUB, nas_pkg::OP_SUBTRACT_WITH_BORROW: begin
            {carry, res} = sub_digit(a, b, (op == nas_pkg::OP_SUBTRACT_WITH_BORROW) & cy_in, bcd);
            is_arith     = 1'b1;
            stores       = 1'b1;
         end
         nas_pkg::OP_OR: begin
            res    = a | b;
            stores = 1'b1;
         end
         nas_pkg::OP_AND: begin
            res    = a & b;
            stores = 1'b1;
         end
         nas_pkg::OP_XOR: begin
            res    = a ^ b;
            stores = 1'b1;
         end
         nas_pkg::OP_SKT: begin
            is_bit = 1'b1;
            skip   = ((a & b) == b);
         end
         nas_pkg::OP_SKF: begin
            is_bit = 1'b1;
            skip   = ((a & b) == nas_pkg::NIB_ZERO);
         end
         nas_pkg::OP_SKE: begin
            is_cmp = 1'b1;
            skip   = (cmp_diff[3:0] == nas_pkg::NIB_ZERO);
         end
         nas_pkg::OP_SKIP_IF_NOT_EQUAL: begin
            is_cmp = 1'b1;
            skip   = (cmp_diff[3:0] != nas_pkg::NIB_ZERO);
         end
         nas_pkg::OP_SKIP_IF_GREATER_EQUAL: begin
            is_cmp = 1'b1;
            skip   = !cmp_diff[4];
         end
         nas_pkg::OP_SKIP_IF_LESS: begin
            is_cmp = 1'b1;
            skip   = cmp_diff[4];
         end
         nas_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
            res    = {cy_in, a[3:1]};
            carry  = a[0];
            stores = 1'b1;
         end
         default: begin
            res = nas_pkg::NIB_ZERO;
         end
      endcase
   end

endmodule : nas_alu_core
`default_nettype wire

/* bench/nas_far_mem.sv */
// Data memory model standing behind the write-back port
`timescale 1ns/1ps
`default_nettype none
module nas_far_mem (
   input wire logic             clock,
   input wire nas_pkg::nas_wb_t wb
);
   logic [3:0] mem [128];

   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 4'(i * 7);
      end
   end

   // Stores land one edge after the strobe, as a real array would
   always @(posedge clock) begin
      if (wb.en) begin
         mem[wb.addr] <= wb.data;
      end
   end
endmodule : nas_far_mem
`default_nettype wire

/* bench/nibble_alu_status_word_test.sv */
// Self-checking testbench of the status word block
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_status_word_test;
   logic                clock = 1'b0;
   logic                reset_n = 1'b0;
   logic                op_valid = 1'b0;
   nas_pkg::nas_req_t   op_req = '0;
   logic                sys_wr_en = 1'b0;
   logic [6:0]          sys_wr_addr = 7'h00;
   logic [3:0]          sys_wr_data = 4'h0;
   logic                sys_rd_en = 1'b0;
   logic [6:0]          sys_rd_addr = 7'h00;
   logic [3:0]          sys_rd_data_q;
   logic                sys_rd_hit_q;
   nas_pkg::nas_wb_t    wb_q;
   logic                skip_q;
   nas_pkg::nas_flags_t flags_q;
   nas_pkg::nas_flags_t m_f;
   logic                e_en, e_skip, e_hit;
   logic [6:0]          e_addr;
   logic [3:0]          e_data, e_rd;
   logic [31:0]         rnd_state = 32'h8368;
   int                  n_mismatch = 0;
   int                  n_compared = 0;

   always #25 clock = ~clock;

   nas_status_word uut (
      .clock(clock),
      .reset_n(reset_n),
      .op_valid(op_valid),
      .op_req(op_req),
      .sys_wr_en(sys_wr_en),
      .sys_wr_addr(sys_wr_addr),
      .sys_wr_data(sys_wr_data),
      .sys_rd_en(sys_rd_en),
      .sys_rd_addr(sys_rd_addr),
      .sys_rd_data_q(sys_rd_data_q),
      .sys_rd_hit_q(sys_rd_hit_q),
      .wb_q(wb_q),
      .skip_q(skip_q),
      .flags_q(flags_q)
   );

   nas_far_mem fm (.clock(clock), .wb(wb_q));

   ////////////////////////////////////////////////////////////////////////
   function automatic int rnd(input int n);
      rnd_state = rnd_state[0] ? (rnd_state >> 1) ^ 32'h80200003 : rnd_state >> 1;
      return int'(rnd_state[15:0]) % n;
   endfunction : rnd

   task check(input string name, input logic [6:0] seen, input logic [6:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task results();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   // One cycle of stimulus on every input but clock and reset_n
   task cyc(input int v, o, a, b, g, col, ma, we, wa, wd, re, ra);
      @(posedge clock);
      op_valid <= 1'(v);
      op_req <= '{nas_pkg::nas_op_t'(o), 4'(a), 4'(b), 1'(g), 4'(col), 7'(ma)};
      sys_wr_en <= 1'(we);
      sys_wr_addr <= 7'(wa);
      sys_wr_data <= 4'(wd);
      sys_rd_en <= 1'(re);
      sys_rd_addr <= 7'(ra);
   endtask : cyc

   ////////////////////////////////////////////////////////////////////////
   // Reference model: compares last cycle's results, then steps
   always @(posedge clock) begin
      int a, b, r, c, ci;
      nas_pkg::nas_flags_t nf;
      if (!reset_n) begin
         m_f = '0;
         e_en = 1'b0;
         e_skip = 1'b0;
         e_rd = 4'h0;
         e_hit = 1'b0;
      end else begin
         check("flags", 7'(flags_q), 7'(m_f));
         check("wb_en", 7'(wb_q.en), 7'(e_en));
         if (e_en) begin
            check("wb_addr", wb_q.addr, e_addr);
            check("wb_data", 7'(wb_q.data), 7'(e_data));
         end
         check("skip", 7'(skip_q), 7'(e_skip));
         check("rd_data", 7'(sys_rd_data_q), 7'(e_rd));
         check("rd_hit", 7'(sys_rd_hit_q), 7'(e_hit));
         e_en = 1'b0;
         e_skip = 1'b0;
         if (sys_rd_en) begin
            e_hit = sys_rd_addr >= 7'h74;
            e_rd = sys_rd_addr == 7'h7F ? {m_f.cmp, m_f.cy, m_f.z, 1'b0} :
                   sys_rd_addr == 7'h7E ? {3'h0, m_f.bcd} : 4'h0;
         end
         nf = m_f;
         a = op_req.a;
         b = op_req.b;
         r = 0;
         if (op_valid) begin
            case (op_req.op)
               nas_pkg::OP_ADD, nas_pkg::OP_ADD_WITH_CARRY, nas_pkg::OP_SUB, nas_pkg::OP_SUBTRACT_WITH_BORROW: begin
                  ci = op_req.op inside {nas_pkg::OP_ADD_WITH_CARRY, nas_pkg::OP_SUBTRACT_WITH_BORROW} ? int'(m_f.cy) : 0;
                  if (op_req.op inside {nas_pkg::OP_SUB, nas_pkg::OP_SUBTRACT_WITH_BORROW}) begin
                     r = a - b - ci;
                     c = int'(r < 0);
                     r = (c != 0 && m_f.bcd) ? r - 6 : r;
                  end else begin
                     r = a + b + ci;
                     c = int'(m_f.bcd ? r > 9 : r > 15);
                     r = (c != 0 && m_f.bcd) ? r + 6 : r;
                  end
                  r = r & 15;
                  nf.cy = c[0];
                  nf.z = m_f.cmp ? (m_f.z && r == 0) : (r == 0);
                  e_en = !m_f.cmp;
               end
               nas_pkg::OP_OR, nas_pkg::OP_AND, nas_pkg::OP_XOR: begin
                  r = op_req.op == nas_pkg::OP_OR ? a | b :
                      op_req.op == nas_pkg::OP_AND ? a & b : a ^ b;
                  e_en = 1'b1;
               end
               nas_pkg::OP_SKT, nas_pkg::OP_SKF: begin
                  e_skip = op_req.op == nas_pkg::OP_SKT ? (a & b) == b : (a & b) == 0;
                  nf.cmp = 1'b0;
               end
               nas_pkg::OP_SKE: e_skip = a == b;
               nas_pkg::OP_SKIP_IF_NOT_EQUAL: e_skip = a != b;
               nas_pkg::OP_SKIP_IF_GREATER_EQUAL: e_skip = a >= b;
               nas_pkg::OP_SKIP_IF_LESS: e_skip = a < b;
               nas_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                  r = (int'(m_f.cy) << 3) | (a >> 1);
                  nf.cy = op_req.a[0];
                  e_en = 1'b1;
               end
               default: r = 0;
            endcase
            e_addr = op_req.dest_gen ? {3'h0, op_req.col} : op_req.m_addr;
            e_data = 4'(r);
         end
         // A software write to the status word overrides the instruction
         if (sys_wr_en && sys_wr_addr >= 7'h7E) begin
            nf = m_f;
            if (sys_wr_addr == 7'h7F) begin
               {nf.cmp, nf.cy, nf.z} = sys_wr_data[3:1];
            end else begin
               nf.bcd = sys_wr_data[0];
            end
         end
         m_f = nf;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int o, a, b, g, col, ma, we, wa, wd, bcd;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      for (int i = 7'h70; i < 8'h80; i++) begin
         cyc(0, 0, 0, 0, 0, 0, 0, 1, i, 15, 1, i);
      end
      for (int i = 7'h70; i <= 8'h80; i++) begin
         cyc(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, i);
      end
      // Chained compare: equal, unequal, equal again, then bit test
      cyc(0, 0, 0, 0, 0, 0, 0, 1, 7'h7F, 4'hA, 0, 0);
      cyc(1, nas_pkg::OP_SUB, 4, 4, 0, 0, 1, 0, 0, 0, 0, 0);
      cyc(1, nas_pkg::OP_SUB, 5, 4, 0, 0, 1, 0, 0, 0, 0, 0);
      cyc(1, nas_pkg::OP_SUB, 4, 4, 0, 0, 1, 0, 0, 0, 0, 0);
      cyc(1, nas_pkg::OP_SKT, 2, 2, 0, 0, 1, 0, 0, 0, 0, 0);
      cyc(1, nas_pkg::OP_ADD, 9, 8, 0, 0, 2, 0, 0, 0, 0, 0);
      repeat (3) cyc(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
      check("mem1", 7'(fm.mem[1]), 7'h07);
      check("mem2", 7'(fm.mem[2]), 7'h07);
      bcd = 1;
      repeat (3000) begin
         o = rnd(15);
         g = rnd(2);
         col = rnd(16);
         ma = rnd(64);
         a = g ? fm.mem[col] : fm.mem[ma];
         b = g ? fm.mem[ma] : rnd(16);
         if (bcd != 0 && o >= 1 && o <= 4) begin
            a = a % 10;
            b = b % 10;
         end
         we = int'(rnd(6) == 0);
         wa = 7'h7C + rnd(4);
         wd = rnd(16);
         cyc(int'(rnd(4) != 0), o, a, b, g, col, ma, we, wa, wd, rnd(2), 7'h70 + rnd(16));
         if (we != 0 && wa == 7'h7E) begin
            bcd = wd & 1;
         end
      end
      repeat (2) cyc(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
      results();
   end

   initial begin
      #250000;
      n_mismatch++;
      results();
   end
endmodule : nibble_alu_status_word_test
`default_nettype wire
